// ==== core/fpe_pkg.sv ====
// Contract
// RQ1 - Flash is 512-byte pages; erase sets every byte of the page to 0xFF.
// RQ2 - Erase: set erase arm, write arm, keys 0xA5 then 0xF1, one data write.
// RQ3 - After erase clear both arms; each further page repeats keys and write.
// RQ4 - Programming only clears bits; only an erase returns bits to one.
// RQ5 - Byte program: check 0xFF, write arm only, both keys, one write, clear arm.
// RQ6 - Each further byte repeats both keys and the write; one unlock, one byte.
// RQ7 - Software saves and disables interrupts around each sequence, then restores.
// RQ8 - Short-address data writes above 0x00FF never erase or program.
// RQ9 - Protected regions such as reserved area and lock page refuse erase and write.
// RQ10 - Software erases two consecutive 512-byte sections together for compatibility.
// RQ11 - Only the two keys in correct order arm; otherwise the write changes nothing.
// RQ12 - Scratchpad select maps 0x0000 to 0x01FF onto a 512-byte scratchpad.
// RQ13 - Data-space writes program Flash; code reads read it; data reads go to RAM.
package fpe_pkg;
  localparam logic [7:0]  FPE_KEY_ADDR      = 8'hB7;
  localparam logic [7:0]  FPE_CTRL_ADDR     = 8'h8F;
  localparam logic [7:0]  FPE_KEY1          = 8'hA5;
  localparam logic [7:0]  FPE_KEY2          = 8'hF1;
  localparam logic [7:0]  FPE_ERASED        = 8'hFF;
  localparam logic [15:0] FPE_SHORT_MAX     = 16'h00FF;
  localparam int          FPE_PAGE_BYTES    = 512;
  localparam int          FPE_ERASE_BIT     = 1;
  localparam int          FPE_WRITE_BIT     = 0;
  localparam int          FPE_SCRATCH_BIT   = 2;
  localparam logic [1:0]  FPE_KEY_LOCKED    = 2'h0;
  localparam logic [1:0]  FPE_KEY_HALF      = 2'h1;
  localparam logic [1:0]  FPE_KEY_ARMED     = 2'h2;
  localparam logic [1:0]  FPE_KEY_FAULT     = 2'h3;
  typedef enum logic [1:0] {FPE_IDLE, FPE_ERASE, FPE_DONE} fpe_state_t;
endpackage

// ==== core/fpe_flash_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_seq
  import fpe_pkg::*;
#(
  parameter int          FLASH_BYTES = 8192,
  parameter logic [15:0] PROT_LO     = 16'h1E00,
  parameter logic [15:0] PROT_HI     = 16'h1FFF
) (
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // Register bus
  input  wire logic        i_sfr_wr,
  input  wire logic        i_sfr_rd,
  input  wire logic [7:0]  i_sfr_addr,
  input  wire logic [7:0]  i_sfr_wdata,
  output logic      [7:0]  o_sfr_rdata,
  // Data-space access
  input  wire logic        i_xwr,
  input  wire logic        i_xwr_short,
  input  wire logic        i_xrd,
  input  wire logic [15:0] i_xaddr,
  input  wire logic [7:0]  i_xwdata,
  // Code-space reads
  input  wire logic        i_code_rd,
  input  wire logic [15:0] i_code_addr,
  input  wire logic        i_code_fetch,
  output logic      [7:0]  o_code_rdata,
  // Status
  output logic             o_external_ram_space_sel,
  output logic             o_busy,
  output logic             o_refused
);
  localparam int AW = $clog2(FLASH_BYTES);
  localparam int PW = $clog2(FPE_PAGE_BYTES);
  // Sizes the address logic can serve
  initial begin
    if (FLASH_BYTES < 2 * FPE_PAGE_BYTES || FLASH_BYTES % FPE_PAGE_BYTES != 0)
      $error("FLASH_BYTES must be a multiple of the page size");
    if ((FLASH_BYTES & (FLASH_BYTES - 1)) != 0)
      $error("FLASH_BYTES must be a power of two");
    if (FLASH_BYTES > 65536)
      $error("FLASH_BYTES exceeds the 16-bit address space");
    if (PROT_LO > PROT_HI)
      $error("protected region bounds are reversed");
    if (PROT_HI >= 16'(FLASH_BYTES))
      $error("protected region lies outside the array");
  end

  // Arrays carry no reset: contents stay undefined until a page is erased
  logic [7:0]    flash_mem [FLASH_BYTES];
  logic [7:0]    scratch_mem [FPE_PAGE_BYTES];
  logic [1:0]    key_state_reg;
  logic [2:0]    ctrl_reg;
  fpe_state_t    state_reg;
  logic [AW-1:0] erase_base_reg;
  logic          erase_scr_reg;
  logic [PW-1:0] erase_cnt_reg;

  logic to_scratch;
  logic in_range;
  logic prot_hit;
  logic short_bad;
  logic armed;
  logic go;
  logic gate_ok;
  logic erase_ok;
  logic prog_ok;
  // Address qualification
  assign to_scratch = ctrl_reg[FPE_SCRATCH_BIT] && (i_xaddr < 16'(FPE_PAGE_BYTES)); // see RQ12
  assign in_range   = to_scratch || (i_xaddr < 16'(FLASH_BYTES));
  assign prot_hit   = !to_scratch && i_xaddr >= PROT_LO && i_xaddr <= PROT_HI; // see RQ9
  assign short_bad  = i_xwr_short && (i_xaddr > FPE_SHORT_MAX); // see RQ8
  assign armed      = key_state_reg == FPE_KEY_ARMED;
  assign go         = i_xwr && ctrl_reg[FPE_WRITE_BIT] && state_reg == FPE_IDLE;
  // A write attempt that passes every gate; the same attempt consumes the unlock
  assign gate_ok    = armed && in_range && !prot_hit && !short_bad; // see RQ8, RQ9, RQ11
  assign erase_ok   = go && gate_ok && ctrl_reg[FPE_ERASE_BIT]; // see RQ2
  assign prog_ok    = go && gate_ok && !ctrl_reg[FPE_ERASE_BIT]; // see RQ4

  // Program store control
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_reg <= 3'h0;
    end else if (i_sfr_wr && i_sfr_addr == FPE_CTRL_ADDR) begin
      ctrl_reg <= i_sfr_wdata[2:0];
    end
  end

  // Unlock key sequencer; a write attempt consumes the unlock
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      key_state_reg <= FPE_KEY_LOCKED;
    end else if (i_sfr_wr && i_sfr_addr == FPE_KEY_ADDR) begin
      if (key_state_reg == FPE_KEY_LOCKED && i_sfr_wdata == FPE_KEY1) begin // see RQ11
        key_state_reg <= FPE_KEY_HALF;
      end else if (key_state_reg == FPE_KEY_HALF && i_sfr_wdata == FPE_KEY2) begin // see RQ11
        key_state_reg <= FPE_KEY_ARMED;
      end else begin
        // Any other value, or a key out of turn, faults until a write attempt relocks
        key_state_reg <= FPE_KEY_FAULT; // see RQ11
      end
    end else if (go) begin
      key_state_reg <= FPE_KEY_LOCKED; // see RQ6
    end
  end

  // Register read mux: key reads back its unlock progress
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      if (i_sfr_addr == FPE_KEY_ADDR) begin
        o_sfr_rdata <= {6'h00, key_state_reg};
      end else if (i_sfr_addr == FPE_CTRL_ADDR) begin
        o_sfr_rdata <= {5'h00, ctrl_reg};
      end else begin
        o_sfr_rdata <= 8'h00;
      end
    end
  end

  // Erase engine state: one page byte per cycle
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= FPE_IDLE;
    end else begin
      case (state_reg)
        FPE_IDLE: begin
          if (erase_ok) begin
            state_reg <= FPE_ERASE; // see RQ2
          end
        end
        FPE_ERASE: begin
          if (&erase_cnt_reg) begin
            state_reg <= FPE_DONE;
          end
        end
        // One settle cycle after an erase before the next write is taken
        default: begin
          state_reg <= FPE_IDLE;
        end
      endcase
    end
  end

  // Erase page capture and byte counter
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      erase_base_reg <= '0;
      erase_scr_reg  <= 1'b0;
      erase_cnt_reg  <= '0;
    end else if (erase_ok) begin
      erase_base_reg <= {i_xaddr[AW-1:PW], {PW{1'b0}}}; // see RQ1
      erase_scr_reg  <= to_scratch;
      erase_cnt_reg  <= '0;
    end else if (state_reg == FPE_ERASE) begin
      erase_cnt_reg <= erase_cnt_reg + 1'b1;
    end
  end

  // Main array: erase fills the page, a program write can only clear bits
  always_ff @(posedge i_mclk) begin
    if (state_reg == FPE_ERASE && !erase_scr_reg) begin
      flash_mem[erase_base_reg | AW'(erase_cnt_reg)] <= FPE_ERASED; // see RQ1
    end else if (prog_ok && !to_scratch) begin
      flash_mem[i_xaddr[AW-1:0]] <= flash_mem[i_xaddr[AW-1:0]] & i_xwdata; // see RQ4, RQ13
    end
  end

  // Scratchpad: same rules on its single page
  always_ff @(posedge i_mclk) begin
    if (state_reg == FPE_ERASE && erase_scr_reg) begin
      scratch_mem[erase_cnt_reg] <= FPE_ERASED; // see RQ1
    end else if (prog_ok && to_scratch) begin
      scratch_mem[i_xaddr[PW-1:0]] <= scratch_mem[i_xaddr[PW-1:0]] & i_xwdata; // see RQ4, RQ12
    end
  end

  // Code-space reads; fetches never see the scratchpad
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_code_rdata <= 8'h00;
    end else if (i_code_rd) begin
      if (ctrl_reg[FPE_SCRATCH_BIT] && !i_code_fetch && i_code_addr < 16'(FPE_PAGE_BYTES)) begin
        o_code_rdata <= scratch_mem[i_code_addr[PW-1:0]]; // see RQ12
      end else if (i_code_addr < 16'(FLASH_BYTES)) begin
        o_code_rdata <= flash_mem[i_code_addr[AW-1:0]]; // see RQ13
      end else begin
        o_code_rdata <= 8'h00;
      end
    end
  end

  // Data-space reads, and writes with programming disarmed, go to external RAM
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_external_ram_space_sel <= 1'b0;
    end else begin
      o_external_ram_space_sel <= i_xrd || (i_xwr && !ctrl_reg[FPE_WRITE_BIT]); // see RQ13
    end
  end

  // Busy follows the erase engine one cycle late
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= state_reg == FPE_ERASE;
    end
  end

  // Refused: a write attempt that missed the unlock or hit a blocked address
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_refused <= 1'b0;
    end else begin
      o_refused <= go && !gate_ok; // see RQ9, RQ11
    end
  end
endmodule
`default_nettype wire

// ==== tb/fpe_flash_seq_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_seq_monitor
  import fpe_pkg::*;
#(
  parameter logic [15:0] PROT_LO = 16'h1E00,
  parameter logic [15:0] PROT_HI = 16'h1FFF
) (
  input wire logic        i_mclk,
  input wire logic        i_arst_n,
  input wire logic        i_xwr,
  input wire logic        i_xwr_short,
  input wire logic        i_xrd,
  input wire logic [15:0] i_xaddr,
  input wire logic        i_code_rd,
  input wire logic        o_busy,
  input wire logic        o_refused,
  input wire logic        o_external_ram_space_sel
);
  logic [9:0] bcnt_reg;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  // Cycles spent in the current erase
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) bcnt_reg <= 10'h000;
    else bcnt_reg <= o_busy ? bcnt_reg + 10'h001 : 10'h000;
  end
  sequence erase_start_s;
    !o_busy ##1 o_busy;
  endsequence
  erase_len_a: assert property (o_busy |-> bcnt_reg < 10'h200)
    else $error("erase too long");
  erase_end_a: assert property ($fell(o_busy) && $past(i_arst_n) |-> $past(bcnt_reg) == 10'h1FF)
    else $error("erase too short");
  erase_gate_a: assert property (erase_start_s |-> $past(i_xwr, 2))
    else $error("erase without data write");
  short_block_a: assert property (i_xwr && i_xwr_short && i_xaddr > FPE_SHORT_MAX && !o_busy && !$past(i_xwr)
                                  |-> ##2 !o_busy)
    else $error("short write erased");
  prot_block_a: assert property (i_xwr && !o_busy && !$past(i_xwr) && i_xaddr >= PROT_LO && i_xaddr <= PROT_HI
                                 |-> ##2 !o_busy)
    else $error("protected page erased");
  refuse_cause_a: assert property (o_refused |-> $past(i_xwr))
    else $error("refusal without write");
  external_ram_space_sel_a: assert property (i_xrd |=> o_external_ram_space_sel)
    else $error("data read missed ram");
  code_path_a: assert property (i_code_rd && !i_xrd && !i_xwr |=> !o_external_ram_space_sel)
    else $error("code read went to ram");
endmodule
bind fpe_flash_seq fpe_flash_seq_monitor #(.PROT_LO(PROT_LO), .PROT_HI(PROT_HI)) u_mon (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fpe_pkg::*;
  logic        i_mclk = 1'b0, i_arst_n = 1'b0, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0, i_xwr = 1'b0;
  logic        i_xwr_short = 1'b0, i_xrd = 1'b0, i_code_rd = 1'b0, i_code_fetch = 1'b0;
  logic [7:0]  i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, i_xwdata = 8'h00, o_sfr_rdata, o_code_rdata;
  logic [15:0] i_xaddr = 16'h0000, i_code_addr = 16'h0000;
  logic        o_external_ram_space_sel, o_busy, o_refused;
  int          bad_count = 0, checked = 0;
  fpe_flash_seq u_fpe_flash_seq (.*);
  always #2.5 i_mclk = ~i_mclk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic sfr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk) {i_sfr_wr, i_sfr_addr, i_sfr_wdata} = {1'b1, a, d};
    @(negedge i_mclk) i_sfr_wr = 1'b0;
  endtask
  task automatic xw(input logic [15:0] a, input logic [7:0] d, input logic s);
    @(negedge i_mclk) {i_xwr, i_xwr_short, i_xaddr, i_xwdata} = {1'b1, s, a, d};
    @(negedge i_mclk) i_xwr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge i_mclk) {i_code_rd, i_code_addr} = {1'b1, a};
    @(negedge i_mclk) i_code_rd = 1'b0;
    chk(o_code_rdata, e);
  endtask
  task automatic rg(input logic [7:0] a, input logic [7:0] e);
    @(negedge i_mclk) {i_sfr_rd, i_sfr_addr} = {1'b1, a};
    @(negedge i_mclk) i_sfr_rd = 1'b0;
    chk(o_sfr_rdata, e);
  endtask
  task automatic unlock(input logic [7:0] ctl);
    sfr(FPE_CTRL_ADDR, ctl);
    sfr(FPE_KEY_ADDR, FPE_KEY1);
    sfr(FPE_KEY_ADDR, FPE_KEY2);
  endtask
  task automatic idle;
    int n;
    @(negedge i_mclk);
    for (n = 0; n < 600 && o_busy !== 1'b0; n++) @(negedge i_mclk);
    if (n == 600) begin
      bad_count++;
      tally_and_finish;
    end
  endtask
  initial begin
    repeat (12) @(negedge i_mclk);
    i_arst_n = 1'b1;
    unlock(8'h03);
    xw(16'h0040, 8'h00, 1'b0);
    @(negedge i_mclk);
    chk(8'(o_busy), 8'h01);
    idle;
    unlock(8'h03);
    xw(16'h0240, 8'h00, 1'b0);
    idle;
    sfr(FPE_CTRL_ADDR, 8'h00);
    rd(16'h0000, FPE_ERASED);
    rd(16'h01FF, FPE_ERASED);
    rd(16'h0200, FPE_ERASED);
    rd(16'h03FF, FPE_ERASED);
    unlock(8'h01);
    rg(FPE_KEY_ADDR, {6'h00, FPE_KEY_ARMED});
    rg(FPE_CTRL_ADDR, 8'h01);
    xw(16'h0040, 8'h5A, 1'b0);
    rd(16'h0040, 8'h5A);
    unlock(8'h01);
    xw(16'h0040, 8'hF0, 1'b0);
    rd(16'h0040, 8'h50);
    xw(16'h0040, 8'h00, 1'b0);
    rd(16'h0040, 8'h50);
    sfr(FPE_KEY_ADDR, FPE_KEY2);
    sfr(FPE_KEY_ADDR, FPE_KEY1);
    rg(FPE_KEY_ADDR, {6'h00, FPE_KEY_FAULT});
    xw(16'h0040, 8'h00, 1'b0);
    chk(8'(o_refused), 8'h01);
    rd(16'h0040, 8'h50);
    unlock(8'h01);
    xw(16'h0100, 8'h00, 1'b1);
    chk(8'(o_refused), 8'h01);
    rd(16'h0100, FPE_ERASED);
    unlock(8'h03);
    xw(16'h1E10, 8'h00, 1'b0);
    chk(8'(o_refused), 8'h01);
    @(negedge i_mclk);
    chk(8'(o_busy), 8'h00);
    unlock(8'h07);
    xw(16'h0040, 8'h00, 1'b0);
    idle;
    sfr(FPE_CTRL_ADDR, 8'h00);
    rd(16'h0040, 8'h50);
    sfr(FPE_CTRL_ADDR, 8'h04);
    rd(16'h0040, FPE_ERASED);
    @(negedge i_mclk) i_xrd = 1'b1;
    @(negedge i_mclk) i_xrd = 1'b0;
    chk(8'(o_external_ram_space_sel), 8'h01);
    tally_and_finish;
  end
endmodule
`default_nettype wire
